// File: design/hvce_top.sv
// host port egress tag/crc editor and host ingress descriptor decoder
// Operation
// - host crc strip set: egress packets carry no crc; clear: they carry one
// - crc kind bit picks ethernet (0) or castagnoli (1) crc on host egress
// - egress crc kind comes from configuration only, never from the packet
// - tag-aware mode off: packets leave unmodified
// - zero vid is priority tag unless zero-id-as-tagged is set
// - untagged, no strip: insert 0x8100 after source address then tag word
// - inserted word is header priority plus ingress port default cfi and vid
// - inserted tag pushes length/type four bytes later, kept intact
// - tag inserted and crc in data: crc regenerated
// - untagged with strip bit set leaves unchanged
// - priority tag, no strip: vid from port default, priority from port map
// - priority tag with strip: whole four-byte tag removed
// - removal with crc in data pads to 60 data bytes from input crc bytes
// - removal without crc in data: no padding
// - tag removal always regenerates the crc
// - vlan tag, no strip: priority replaced, crc regenerated when present
// - vlan tag with strip: removed, same pad and crc handling
// - host ingress takes 128-bit stream words on one stream
// - descriptor word 1 bits 7-0: directed destination, 0 not directed
// - descriptor word 2 bit 19: crc included flag
// - descriptor word 2 bit 18: ingress crc kind, per packet
// - no crc included: crc generated on ingress; else forwarded unchanged
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "hvce_consts.svh"
module hvce_top (
  input  wire logic                SYS_CLK,
  input  wire logic                NRST,
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic [31:0]         REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic [31:0]              REG_RDATA,
  input  wire hvce_pkg::hvce_word_s EG_IN,
  input  wire hvce_pkg::hvce_meta_s EG_IN_META,
  input  wire logic                EG_IN_VALID,
  output logic                     EG_IN_READY,
  output hvce_pkg::hvce_word_s     EG_OUT,
  output hvce_pkg::hvce_crc_s      EG_OUT_CRC,
  output logic                     EG_OUT_VALID,
  input  wire logic                EG_OUT_READY,
  input  wire logic                DESC_VALID,
  input  wire logic [31:0]         DESC_WORD1,
  input  wire logic [31:0]         DESC_WORD2,
  output hvce_pkg::hvce_desc_s     DESC_OUT,
  output logic                     DESC_OUT_VALID
);
  logic [3:0]  ctrl_reg;
  logic [12:0] tag_reg [0:`HVCE_NPORTS-1];
  logic [23:0] map_reg [0:`HVCE_NPORTS-1];
  logic [15:0] pkt_cnt_reg;

  // register decode; each port owns one word in the tag and map windows
  wire [7:0] tag_off = REG_ADDR - `HVCE_ADDR_TAG0;
  wire [7:0] map_off = REG_ADDR - `HVCE_ADDR_MAP0;
  wire       tag_hit = (tag_off < `HVCE_PORT_SPAN) && (tag_off[1:0] == 2'b00);
  wire       map_hit = (map_off < `HVCE_PORT_SPAN) && (map_off[1:0] == 2'b00);
  wire [2:0] tag_i = tag_off[4:2];
  wire [2:0] map_i = map_off[4:2];
  wire       wr_ctrl = REG_WR && (REG_ADDR == `HVCE_ADDR_CTRL);

  hvce_pkg::hvce_phase_e phase_reg;
  wire [31:0] rd_mux = (REG_ADDR == `HVCE_ADDR_CTRL) ? {28'h0000000, ctrl_reg} :
                       (REG_ADDR == `HVCE_ADDR_STAT) ?
                         {15'h0000, (phase_reg != hvce_pkg::PH_IDLE), pkt_cnt_reg} :
                       tag_hit ? {19'h00000, tag_reg[tag_i]} :
                       map_hit ? {8'h00, map_reg[map_i]} : 32'h00000000;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg  <= `HVCE_CTRL_RST;
      REG_RDATA <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= REG_WDATA[3:0];
      end
      REG_RDATA <= REG_RD ? rd_mux : 32'h00000000;
    end
  end

  for (genvar g = 0; g < `HVCE_NPORTS; g++) begin : g_port
    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        tag_reg[g] <= `HVCE_TAG_RST;
        map_reg[g] <= `HVCE_MAP_RST;
      end else begin
        if (REG_WR && tag_hit && (tag_i == 3'(g))) begin
          tag_reg[g] <= REG_WDATA[12:0];
        end
        if (REG_WR && map_hit && (map_i == 3'(g))) begin
          map_reg[g] <= REG_WDATA[23:0];
        end
      end
    end
  end

  // classification of the first word of a packet, as it is taken
  wire [7:0]  b12 = EG_IN.data[103:96];
  wire [7:0]  b13 = EG_IN.data[111:104];
  wire [7:0]  b14 = EG_IN.data[119:112];
  wire [7:0]  b15 = EG_IN.data[127:120];
  wire        is_tagged = ({b12, b13} == `HVCE_TPID);
  wire [11:0] pkt_vid = {b14[3:0], b15};
  wire        prio_tag = is_tagged && (pkt_vid == 12'h000) && !ctrl_reg[`HVCE_CTRL_ZERO];
  wire        port_ok = (EG_IN_META.src_port < 3'(`HVCE_NPORTS));
  wire [12:0] def_tag = port_ok ? tag_reg[EG_IN_META.src_port] : `HVCE_TAG_RST;
  wire [23:0] pri_map = port_ok ? map_reg[EG_IN_META.src_port] : `HVCE_MAP_RST;
  wire [2:0]  hdr_pri = pri_map[{EG_IN_META.rx_pri, 1'b0} + {2'b00, EG_IN_META.rx_pri} +: 3];
  wire [15:0] new_tci = !is_tagged ? {hdr_pri, def_tag} :
                        prio_tag ? {hdr_pri, b14[4], def_tag[11:0]} :
                        {hdr_pri, b14[4], pkt_vid};
  wire hvce_pkg::hvce_edit_e edit_sel =
      !ctrl_reg[`HVCE_CTRL_AWARE] ? hvce_pkg::ED_NONE :
      !is_tagged ? (EG_IN_META.strip_tag ? hvce_pkg::ED_NONE :
                                           hvce_pkg::ED_INS) :
      (EG_IN_META.strip_tag ? hvce_pkg::ED_STRIP : hvce_pkg::ED_REPL);

  hvce_pkg::hvce_word_s  in_reg;
  hvce_pkg::hvce_meta_s  meta_reg;
  hvce_pkg::hvce_edit_e  edit_reg;
  logic        in_full_reg;
  logic [3:0]  lane_reg;
  logic [15:0] pos_reg;
  logic [15:0] tci_reg;
  logic [2:0]  ins_cnt_reg;
  logic        pkt_strip_reg;
  logic        pkt_kind_reg;
  logic [31:0] dly_reg;
  logic [2:0]  dly_cnt_reg;
  logic [127:0] acc_reg;
  logic [4:0]  acc_cnt_reg;
  logic [15:0] ocnt_reg;
  logic [31:0] crc_reg;
  logic [1:0]  crc_idx_reg;
  logic        first_reg;

  wire accept = EG_IN_VALID && EG_IN_READY;
  wire go = !EG_OUT_VALID || EG_OUT_READY;
  wire step_data = (phase_reg == hvce_pkg::PH_DATA) && in_full_reg && go;
  wire step_tail = (phase_reg == hvce_pkg::PH_TAIL) && go;
  wire step_crc  = (phase_reg == hvce_pkg::PH_CRC) && go;
  wire step_end  = (phase_reg == hvce_pkg::PH_END) && go;

  wire [7:0]  cur_byte = in_reg.data[{lane_reg, 3'b000} +: 8];
  wire        last_lane = ({1'b0, lane_reg} == (in_reg.nbytes - 5'd1));
  wire [31:0] tag_word = {`HVCE_TPID, tci_reg};
  // insertion holds the input byte, so length/type slips four bytes later
  wire        ins_now = (edit_reg == hvce_pkg::ED_INS) && (pos_reg == `HVCE_TAG_POS)
                        && (ins_cnt_reg != 3'd4);
  wire        skip = (edit_reg == hvce_pkg::ED_STRIP) && (pos_reg >= `HVCE_TAG_POS)
                     && (pos_reg < `HVCE_TAG_POS + 16'd4);
  wire        repl_hi = (edit_reg == hvce_pkg::ED_REPL) && (pos_reg == `HVCE_TCI_POS);
  wire        repl_lo = (edit_reg == hvce_pkg::ED_REPL) && (pos_reg == `HVCE_TCI_POS + 16'd1);
  wire [7:0]  emit_byte = ins_now ? tag_word[{2'd3 - ins_cnt_reg[1:0], 3'b000} +: 8] :
                          repl_hi ? tci_reg[15:8] :
                          repl_lo ? tci_reg[7:0] : cur_byte;
  wire        emit = step_data && (ins_now || !skip);
  wire        consume = step_data && !ins_now;
  // with crc in the data, the last four bytes sit in the delay line at the end
  wire        to_dly = emit && meta_reg.crc_in;
  wire        pad_now = step_tail && (edit_reg == hvce_pkg::ED_STRIP) && meta_reg.crc_in
                        && (ocnt_reg < `HVCE_MIN_DATA) && (dly_cnt_reg != 3'd0);
  wire        dly_pop = (to_dly && (dly_cnt_reg == 3'd4)) || pad_now;
  // original crc survives only if nothing changed and its kind already fits
  wire        pass_orig = (edit_reg == hvce_pkg::ED_NONE) && meta_reg.crc_in
                          && (meta_reg.crc_kind_in == pkt_kind_reg)
                          && (dly_cnt_reg == 3'd4);
  wire [31:0] crc_src = pass_orig ? dly_reg : ~crc_reg;
  wire [7:0]  crc_byte = crc_src[{crc_idx_reg, 3'b000} +: 8];
  wire        push_en = (emit && !meta_reg.crc_in) || dly_pop || step_crc;
  wire [7:0]  push_byte = (emit && !meta_reg.crc_in) ? emit_byte :
                          step_crc ? crc_byte : dly_reg[7:0];
  wire        push_data = push_en && !step_crc;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      phase_reg   <= hvce_pkg::PH_IDLE;
      EG_IN_READY <= 1'b0;
      in_full_reg <= 1'b0;
      in_reg      <= '0;
      meta_reg    <= '0;
      edit_reg    <= hvce_pkg::ED_NONE;
      tci_reg     <= 16'h0000;
      lane_reg    <= 4'h0;
      pos_reg     <= 16'h0000;
      ins_cnt_reg <= 3'd0;
      pkt_strip_reg <= 1'b0;
      pkt_kind_reg  <= 1'b0;
      crc_idx_reg <= 2'd0;
      pkt_cnt_reg <= 16'h0000;
    end else begin
      if (phase_reg == hvce_pkg::PH_IDLE) begin
        EG_IN_READY <= !accept;
      end
      if (accept) begin
        in_reg      <= EG_IN;
        in_full_reg <= 1'b1;
        EG_IN_READY <= 1'b0;
        lane_reg    <= 4'h0;
        if (phase_reg == hvce_pkg::PH_IDLE) begin
          phase_reg <= hvce_pkg::PH_DATA;
        end
        if (EG_IN.sop) begin
          meta_reg      <= EG_IN_META;
          edit_reg      <= edit_sel;
          tci_reg       <= new_tci;
          pos_reg       <= 16'h0000;
          ins_cnt_reg   <= 3'd0;
          pkt_strip_reg <= ctrl_reg[`HVCE_CTRL_STRIP];
          pkt_kind_reg  <= ctrl_reg[`HVCE_CTRL_KIND];
        end
      end
      if (ins_now && step_data) begin
        ins_cnt_reg <= ins_cnt_reg + 3'd1;
      end
      if (consume) begin
        lane_reg <= lane_reg + 4'h1;
        pos_reg  <= pos_reg + 16'h0001;
        if (last_lane) begin
          in_full_reg <= 1'b0;
          EG_IN_READY <= !in_reg.eop;
          if (in_reg.eop) begin
            phase_reg <= hvce_pkg::PH_TAIL;
          end
        end
      end
      if (step_tail && !pad_now) begin
        phase_reg   <= pkt_strip_reg ? hvce_pkg::PH_END : hvce_pkg::PH_CRC;
        crc_idx_reg <= 2'd0;
      end
      if (step_crc) begin
        crc_idx_reg <= crc_idx_reg + 2'd1;
        if (crc_idx_reg == 2'd3) begin
          phase_reg <= hvce_pkg::PH_END;
        end
      end
      if (step_end) begin
        phase_reg   <= hvce_pkg::PH_IDLE;
        EG_IN_READY <= 1'b1;
        pkt_cnt_reg <= pkt_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      dly_reg     <= 32'h00000000;
      dly_cnt_reg <= 3'd0;
    end else if (step_end) begin
      dly_cnt_reg <= 3'd0;
    end else if (to_dly && (dly_cnt_reg == 3'd4)) begin
      dly_reg <= {emit_byte, dly_reg[31:8]};
    end else if (to_dly) begin
      dly_reg[{dly_cnt_reg[1:0], 3'b000} +: 8] <= emit_byte;
      dly_cnt_reg <= dly_cnt_reg + 3'd1;
    end else if (pad_now) begin
      dly_reg     <= {8'h00, dly_reg[31:8]};
      dly_cnt_reg <= dly_cnt_reg - 3'd1;
    end
  end

  // a full word is held back until the next byte, so the last word always carries eop
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      acc_reg      <= 128'h0;
      acc_cnt_reg  <= 5'd0;
      ocnt_reg     <= 16'h0000;
      crc_reg      <= `HVCE_CRC_INIT;
      first_reg    <= 1'b1;
      EG_OUT       <= '0;
      EG_OUT_VALID <= 1'b0;
      EG_OUT_CRC   <= '0;
    end else begin
      if (EG_OUT_VALID && EG_OUT_READY) begin
        EG_OUT_VALID <= 1'b0;
      end
      if (push_en && (acc_cnt_reg == 5'd16)) begin
        EG_OUT       <= '{data: acc_reg, sop: first_reg, eop: 1'b0, nbytes: 5'd16};
        EG_OUT_VALID <= 1'b1;
        first_reg    <= 1'b0;
        acc_reg      <= {120'h0, push_byte};
        acc_cnt_reg  <= 5'd1;
      end else if (push_en) begin
        acc_reg[{acc_cnt_reg[3:0], 3'b000} +: 8] <= push_byte;
        acc_cnt_reg <= acc_cnt_reg + 5'd1;
      end
      if (push_data) begin
        ocnt_reg <= ocnt_reg + 16'h0001;
        crc_reg  <= hvce_pkg::hvce_crc_step(crc_reg, push_byte, pkt_kind_reg);
      end
      if (step_end) begin
        EG_OUT       <= '{data: acc_reg, sop: first_reg, eop: 1'b1, nbytes: acc_cnt_reg};
        EG_OUT_VALID <= 1'b1;
        EG_OUT_CRC   <= '{present: !pkt_strip_reg, kind: pkt_kind_reg};
        first_reg    <= 1'b1;
        acc_cnt_reg  <= 5'd0;
        ocnt_reg     <= 16'h0000;
        crc_reg      <= `HVCE_CRC_INIT;
      end
    end
  end

  // host ingress descriptor decode; directing to several ports is the sender's fault
  wire [7:0] d_dest = DESC_WORD1[7:0];
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      DESC_OUT       <= '0;
      DESC_OUT_VALID <= 1'b0;
    end else begin
      DESC_OUT_VALID <= DESC_VALID;
      if (DESC_VALID) begin
        DESC_OUT <= '{directed: (d_dest != 8'h00) && (d_dest < 8'(`HVCE_NPORTS)),
                      reserved: (d_dest >= 8'(`HVCE_NPORTS)),
                      dest: d_dest,
                      gen_crc: !DESC_WORD2[`HVCE_D2_PASS_CRC],
                      crc_kind: DESC_WORD2[`HVCE_D2_CRC_KIND]};
      end
    end
  end

  sequence s_end_step;
    step_end;
  endsequence
  property p_crc_presence;
    @(posedge SYS_CLK) disable iff (!NRST)
      s_end_step |=> EG_OUT_VALID && EG_OUT.eop && (EG_OUT_CRC.present == !pkt_strip_reg);
  endproperty
  a_crc_presence: assert property (p_crc_presence) else $error("crc presence wrong");
  property p_crc_kind;
    @(posedge SYS_CLK) disable iff (!NRST)
      s_end_step |=> (EG_OUT_CRC.kind == $past(ctrl_reg[`HVCE_CTRL_KIND], 1)) ||
                     $past(accept && EG_IN.sop, 1) || $past(wr_ctrl, 1);
  endproperty
  a_crc_kind: assert property (p_crc_kind) else $error("crc kind not from config");
  property p_unmodified;
    @(posedge SYS_CLK) disable iff (!NRST)
      (step_data && (edit_reg == hvce_pkg::ED_NONE)) |-> emit && (emit_byte == cur_byte);
  endproperty
  a_unmodified: assert property (p_unmodified) else $error("packet changed");
  sequence s_ins_start;
    step_data && ins_now && (ins_cnt_reg == 3'd0);
  endsequence
  property p_insert_tpid;
    @(posedge SYS_CLK) disable iff (!NRST)
      s_ins_start |-> (emit_byte == 8'h81) && !consume;
  endproperty
  a_insert_tpid: assert property (p_insert_tpid) else $error("tag type byte wrong");
  property p_strip_skip;
    @(posedge SYS_CLK) disable iff (!NRST)
      (step_data && skip) |-> !emit ##1 (pos_reg == $past(pos_reg) + 16'h0001);
  endproperty
  a_strip_skip: assert property (p_strip_skip) else $error("tag byte not removed");
  property p_pad;
    @(posedge SYS_CLK) disable iff (!NRST)
      pad_now |=> (ocnt_reg == $past(ocnt_reg) + 16'h0001) && (ocnt_reg <= `HVCE_MIN_DATA);
  endproperty
  a_pad: assert property (p_pad) else $error("pad step wrong");
  property p_no_pad;
    @(posedge SYS_CLK) disable iff (!NRST)
      ((phase_reg == hvce_pkg::PH_TAIL) && !meta_reg.crc_in) |=> $stable(ocnt_reg);
  endproperty
  a_no_pad: assert property (p_no_pad) else $error("padding without crc");
  property p_regen;
    @(posedge SYS_CLK) disable iff (!NRST)
      (step_crc && (edit_reg != hvce_pkg::ED_NONE)) |->
        (push_byte == ~crc_reg[{crc_idx_reg, 3'b000} +: 8]);
  endproperty
  a_regen: assert property (p_regen) else $error("crc not regenerated");
  property p_desc;
    @(posedge SYS_CLK) disable iff (!NRST)
      DESC_VALID |=> DESC_OUT_VALID && (DESC_OUT.dest == $past(DESC_WORD1[7:0])) &&
                     (DESC_OUT.gen_crc != $past(DESC_WORD2[`HVCE_D2_PASS_CRC])) &&
                     (DESC_OUT.crc_kind == $past(DESC_WORD2[`HVCE_D2_CRC_KIND]));
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor wrong");
  property p_in_hold;
    @(posedge SYS_CLK) disable iff (!NRST)
      in_full_reg |-> !EG_IN_READY;
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("word overrun");
endmodule
`default_nettype wire

// File: common/hvce_consts.svh
// constants of the host port tag and crc editor
`ifndef HVCE_CONSTS_SVH
`define HVCE_CONSTS_SVH
`define HVCE_NPORTS      5
`define HVCE_ADDR_CTRL   8'h00
`define HVCE_ADDR_TAG0   8'h10
`define HVCE_ADDR_MAP0   8'h30
`define HVCE_ADDR_STAT   8'h50
`define HVCE_PORT_SPAN   8'h14
`define HVCE_CTRL_STRIP  0
`define HVCE_CTRL_KIND   1
`define HVCE_CTRL_AWARE  2
`define HVCE_CTRL_ZERO   3
`define HVCE_CTRL_RST    4'h0
`define HVCE_TAG_RST     13'h0000
`define HVCE_MAP_RST     24'hfac688
`define HVCE_TPID        16'h8100
`define HVCE_TAG_POS     16'h000c
`define HVCE_TCI_POS     16'h000e
`define HVCE_MIN_DATA    16'h003c
`define HVCE_CRC_INIT    32'hffffffff
`define HVCE_POLY_ETH    32'hedb88320
`define HVCE_POLY_CAS    32'h82f63b78
`define HVCE_D2_PASS_CRC 19
`define HVCE_D2_CRC_KIND 18
`endif

// File: common/hvce_pkg.sv
// types and crc step shared by the host port tag and crc editor
`default_nettype none
`include "hvce_consts.svh"
package hvce_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DATA = 3'b001,
    PH_TAIL = 3'b010,
    PH_CRC  = 3'b011,
    PH_END  = 3'b100
  } hvce_phase_e;
  typedef enum logic [1:0] {
    ED_NONE  = 2'b00,
    ED_INS   = 2'b01,
    ED_REPL  = 2'b10,
    ED_STRIP = 2'b11
  } hvce_edit_e;
  typedef struct packed {
    logic [127:0] data;
    logic         sop;
    logic         eop;
    logic [4:0]   nbytes;
  } hvce_word_s;
  typedef struct packed {
    logic [2:0] src_port;
    logic [2:0] rx_pri;
    logic       strip_tag;
    logic       crc_in;
    logic       crc_kind_in;
  } hvce_meta_s;
  typedef struct packed {
    logic present;
    logic kind;
  } hvce_crc_s;
  typedef struct packed {
    logic       directed;
    logic       reserved;
    logic [7:0] dest;
    logic       gen_crc;
    logic       crc_kind;
  } hvce_desc_s;
  // reflected crc over one byte, lsb first
  function automatic logic [31:0] hvce_crc_step(input logic [31:0] crc,
                                                input logic [7:0]  din,
                                                input logic        kind);
    logic [31:0] c;
    logic [31:0] poly;
    c = crc ^ {24'h000000, din};
    poly = kind ? `HVCE_POLY_CAS : `HVCE_POLY_ETH;
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ poly) : (c >> 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// File: sim/hvce_sink.sv
// sink model of the packet streaming switch at the host egress stream
`timescale 1ns/10ps
`default_nettype none
module hvce_sink (
  input  wire logic                 SYS_CLK,
  input  wire logic                 NRST,
  input  wire logic                 SLOW,
  input  wire hvce_pkg::hvce_word_s EG_OUT,
  input  wire hvce_pkg::hvce_crc_s  EG_OUT_CRC,
  input  wire logic                 EG_OUT_VALID,
  output logic                      EG_OUT_READY
);
  logic [7:0]          q[$];
  hvce_pkg::hvce_crc_s crc;
  int                  pkts;
  logic                tog;
  // slow mode refuses every other cycle so the editor has to stall
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      EG_OUT_READY <= 1'b0;
      tog <= 1'b0;
      pkts <= 0;
    end else begin
      tog <= ~tog;
      EG_OUT_READY <= !SLOW || tog;
      if (EG_OUT_VALID && EG_OUT_READY) begin
        for (int k = 0; k < 16; k++) begin
          if (k < EG_OUT.nbytes) q.push_back(EG_OUT.data[8*k+:8]);
        end
        if (EG_OUT.eop) begin
          crc <= EG_OUT_CRC;
          pkts <= pkts + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/hvce_top_test.sv
// self-checking bench of the host port tag and crc editor
`timescale 1ns/10ps
`default_nettype none
`include "hvce_consts.svh"
module hvce_top_test;
  logic                 clk, nrst, wr_s, rd_s, eg_valid, eg_ready, o_valid, o_ready;
  logic                 slow, desc_valid, desc_out_valid;
  logic [7:0]           addr;
  logic [31:0]          wdata, rdata, desc_w1, desc_w2;
  hvce_pkg::hvce_word_s eg_in, eg_out;
  hvce_pkg::hvce_meta_s eg_meta;
  hvce_pkg::hvce_crc_s  o_crc;
  hvce_pkg::hvce_desc_s desc_out;
  logic [7:0]           pb[$], ex[$];
  int                   miscompares, compares, np;
  hvce_top dut (.SYS_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .EG_IN(eg_in), .EG_IN_META(eg_meta),
    .EG_IN_VALID(eg_valid), .EG_IN_READY(eg_ready), .EG_OUT(eg_out), .EG_OUT_CRC(o_crc),
    .EG_OUT_VALID(o_valid), .EG_OUT_READY(o_ready), .DESC_VALID(desc_valid),
    .DESC_WORD1(desc_w1), .DESC_WORD2(desc_w2), .DESC_OUT(desc_out),
    .DESC_OUT_VALID(desc_out_valid));
  hvce_sink snk (.SYS_CLK(clk), .NRST(nrst), .SLOW(slow), .EG_OUT(eg_out),
    .EG_OUT_CRC(o_crc), .EG_OUT_VALID(o_valid), .EG_OUT_READY(o_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e, "reg");
    @(posedge clk);
  endtask
  // header bytes 12..15 carry the type word and the tag word
  task automatic mk(input int n, input logic [15:0] t, input logic [15:0] tci);
    pb.delete();
    for (int i = 0; i < n; i++) pb.push_back(8'(i * 7 + 3));
    pb[12] = t[15:8];
    pb[13] = t[7:0];
    pb[14] = tci[15:8];
    pb[15] = tci[7:0];
  endtask
  task automatic send(input hvce_pkg::hvce_meta_s m);
    hvce_pkg::hvce_word_s wd;
    for (int w = 0; w < pb.size(); w += 16) begin
      wd = '0;
      for (int k = 0; k < 16 && w + k < pb.size(); k++) wd.data[8*k+:8] = pb[w+k];
      wd.sop = (w == 0);
      wd.eop = (w + 16 >= pb.size());
      wd.nbytes = 5'((pb.size() - w > 16) ? 16 : pb.size() - w);
      eg_in <= wd;
      eg_meta <= m;
      eg_valid <= 1'b1;
      @(posedge clk iff eg_ready);
    end
    eg_valid <= 1'b0;
  endtask
  // regen clear: the last four input bytes must come out untouched as the crc
  task automatic expect_pkt(input logic pres, input logic kind, input logic regen);
    int t;
    logic [31:0] c;
    t = 0;
    while (snk.pkts == np && t < 2000) begin
      @(posedge clk);
      t++;
    end
    if (snk.pkts == np) begin
      miscompares++;
      $display("wrong value at %0t: no packet out", $time);
    end
    np = snk.pkts;
    chk(32'(snk.q.size()), 32'(ex.size() + (pres ? 4 : 0)), "len");
    for (int i = 0; i < ex.size() && i < snk.q.size(); i++) chk(32'(snk.q[i]), 32'(ex[i]), "byte");
    chk(32'(snk.crc.present), 32'(pres), "crc");
    if (pres) chk(32'(snk.crc.kind), 32'(kind), "kind");
    c = `HVCE_CRC_INIT;
    foreach (ex[i]) begin
      c = c ^ {24'h000000, ex[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ (kind ? `HVCE_POLY_CAS : `HVCE_POLY_ETH)) : (c >> 1);
      end
    end
    for (int k = 0; pres && k < 4 && ex.size() + k < snk.q.size(); k++) begin
      chk(32'(snk.q[ex.size() + k]),
          32'(regen ? 8'(~c >> (8 * k)) : pb[pb.size() - 4 + k]), "crc byte");
    end
    snk.q.delete();
  endtask
  task automatic t_regs();
    rd(`HVCE_ADDR_CTRL, 32'h0);
    rd(`HVCE_ADDR_MAP0, 32'h00fac688);
    wr(8'h7c, 32'hffffffff);
    rd(8'h7c, 32'h0);
    wr(`HVCE_ADDR_CTRL, 32'hf);
    rd(`HVCE_ADDR_CTRL, 32'hf);
    $display("test regs done");
  endtask
  task automatic t_host();
    for (int i = 0; i < 4; i++) begin
      slow <= i[1];
      wr(`HVCE_ADDR_CTRL, {30'h0, i[1], i[0]});
      mk(64, 16'h8100, 16'h0000);
      ex = pb[0:59];
      send({3'h1, 3'h2, 1'b1, 1'b1, ~i[1]});
      expect_pkt(~i[0], i[1], 1'b1);
    end
    slow <= 1'b0;
    rd(`HVCE_ADDR_STAT, 32'h4);
    $display("test host crc done");
  endtask
  task automatic t_ins();
    wr(`HVCE_ADDR_TAG0 + 8'h04, 32'h1123);
    rd(`HVCE_ADDR_TAG0 + 8'h04, 32'h1123);
    wr(`HVCE_ADDR_MAP0 + 8'h04, 32'h00f94688);
    wr(`HVCE_ADDR_CTRL, 32'h4);
    for (int s = 0; s < 2; s++) begin
      mk(64, 16'h0800, 16'h0000);
      ex = pb[0:59];
      if (s == 0) begin
        ex.insert(12, 8'h81);
        ex.insert(13, 8'h00);
        ex.insert(14, 8'h51);
        ex.insert(15, 8'h23);
      end
      send({3'h1, 3'h5, s[0], 1'b1, 1'b0});
      expect_pkt(1'b1, 1'b0, (s == 0));
    end
    $display("test insert done");
  endtask
  task automatic t_tag();
    logic [15:0] tin[3] = '{16'hc000, 16'hc000, 16'hd055};
    logic [15:0] tex[3] = '{16'h4123, 16'h4000, 16'h5055};
    for (int c = 0; c < 3; c++) begin
      wr(`HVCE_ADDR_CTRL, (c == 1) ? 32'hc : 32'h4);
      mk(68, 16'h8100, tin[c]);
      ex = pb[0:63];
      ex[14] = tex[c][15:8];
      ex[15] = tex[c][7:0];
      send({3'h1, 3'h5, 1'b0, 1'b1, 1'b0});
      expect_pkt(1'b1, 1'b0, 1'b1);
    end
    $display("test replace done");
  endtask
  // 66 bytes: with crc the 58 left are padded to 60 from crc bytes
  task automatic t_strip();
    wr(`HVCE_ADDR_CTRL, 32'h4);
    for (int c = 0; c < 4; c++) begin
      mk(66, 16'h8100, c[1] ? 16'hd055 : 16'hc000);
      ex = pb;
      for (int k = 0; k < 4; k++) ex.delete(12);
      ex = ex[0:(c[0] ? 59 : 61)];
      send({3'h1, 3'h5, 1'b1, c[0], 1'b0});
      expect_pkt(1'b1, 1'b0, 1'b1);
    end
    $display("test strip done");
  endtask
  task automatic t_desc();
    logic [31:0] w1[4] = '{32'h2, 32'hab00, 32'h4, 32'h5};
    logic [31:0] w2[4] = '{32'h0, 32'hc0000, 32'h80000, 32'h40000};
    logic [11:0] de[4] = '{12'h80a, 12'h001, 12'h810, 12'h416};
    logic [11:0] m;
    for (int c = 0; c < 4; c++) begin
      m = de[c][1] ? 12'hffe : 12'hfff;
      desc_w1 <= w1[c];
      desc_w2 <= w2[c];
      desc_valid <= 1'b1;
      @(posedge clk);
      desc_valid <= 1'b0;
      #1 chk(32'(desc_out_valid), 32'h1, "dvalid");
      chk(32'(desc_out & m), 32'(de[c] & m), "desc");
      @(posedge clk);
    end
    $display("test descriptor done");
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    {nrst, wr_s, rd_s, eg_valid, slow, desc_valid} = '0;
    {addr, wdata, desc_w1, desc_w2, eg_in, eg_meta} = '0;
    {miscompares, compares, np} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_host();
    t_ins();
    t_tag();
    t_strip();
    t_desc();
    results();
  end
endmodule
`default_nettype wire
